//--- logic/dpc_cfg.svh
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH

// Register indices, byte address is four times the index
`define DPC_IDX_MODE 5'h00
`define DPC_IDX_STATUS 5'h01
`define DPC_IDX_TONE 5'h02
`define DPC_IDX_CLOCK 5'h03
`define DPC_IDX_DTIME 5'h04
`define DPC_IDX_SRATE 5'h05
`define DPC_IDX_HDR_LO 5'h08
`define DPC_IDX_HDR_HI 5'h09
`define DPC_IDX_VOLUME 5'h0b
`define DPC_IDX_FILL 5'h10
`define DPC_IDX_SPEED 5'h11
`define DPC_IDX_BRATE 5'h12
`define DPC_IDX_POS 5'h13

// Mode and status fields
`define DPC_MODE_RESET_BIT 2
`define DPC_MODE_CANCEL_BIT 3
`define DPC_MODE_RANGE_BIT 15
`define DPC_STAT_DECODING_BIT 0
`define DPC_STAT_NOJUMP_BIT 15
`define DPC_MULT_HI 15
`define DPC_MULT_LO 13

// Reset values
`define DPC_MODE_RST 16'h0000
`define DPC_CLOCK_RST 16'h0000
`define DPC_VOLUME_RST 16'h0000
`define DPC_VOLUME_OFF 16'hffff
`define DPC_SPEED_RST 16'h0001
`define DPC_POS_NONE 16'hffff
`define DPC_FILL_RST 8'h00

// Timing
`define DPC_CLK_HZ 20000000
`define DPC_SEC_CYCLES (`DPC_CLK_HZ)
`define DPC_MS_CYCLES (`DPC_CLK_HZ / 1000)
`define DPC_HOLDOFF_CYCLES 22000
`define DPC_IDLE_FILL_BYTES 2048
`define DPC_CANCEL_BYTES 32
`define DPC_HEADER_BYTES 64

`endif

//--- logic/dpc_holdoff.sv
`timescale 1ns/1ps
`include "dpc_cfg.svh"

module dpc_holdoff
  import dpc_pkg::*;
#(
  parameter int CYCLES = `DPC_HOLDOFF_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic tick,
  output logic done
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_reg;

  // Counts internal clock cycles, not bus cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (restart) begin
      cnt_reg <= '0;
    end else if (tick && cnt_reg != W'(CYCLES)) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign done = (cnt_reg == W'(CYCLES)) && !restart;

  a_done_on_tick: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(done) |-> $past(tick))
    else $error("Hold-off ended without an internal clock tick");

endmodule

//--- logic/dpc_pkg.sv
package dpc_pkg;

  typedef enum logic [1:0] {
    DPC_BUS_IDLE,
    DPC_BUS_WR,
    DPC_BUS_RD1,
    DPC_BUS_RD2
  } dpc_bus_state_t;

  typedef enum logic [1:0] {
    DPC_ST_IDLE,
    DPC_ST_PLAY,
    DPC_ST_CANCEL
  } dpc_stream_state_t;

endpackage

//--- logic/dpc_stream.sv
`timescale 1ns/1ps
`include "dpc_cfg.svh"

module dpc_stream
  import dpc_pkg::*;
#(
  parameter int IDLE_FILL = `DPC_IDLE_FILL_BYTES,
  parameter int CANCEL_BYTES = `DPC_CANCEL_BYTES,
  parameter int HEADER_BYTES = `DPC_HEADER_BYTES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic [7:0] byte_in,
  input wire logic byte_valid,
  input wire logic [7:0] fill_byte,
  input wire logic cancel_req,
  output logic decoding,
  output logic no_jump,
  output logic cancel_done
);

  dpc_stream_state_t state_reg;
  logic [15:0] run_reg;
  logic [15:0] hdr_reg;
  logic is_fill;

  assign is_fill = byte_in == fill_byte;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= DPC_ST_IDLE;
      run_reg <= 16'h0000;
      cancel_done <= 1'b0;
    end else if (restart) begin
      state_reg <= DPC_ST_IDLE;
      run_reg <= 16'h0000;
      cancel_done <= 1'b0;
    end else begin
      cancel_done <= 1'b0;
      unique case (state_reg)
        DPC_ST_IDLE: begin
          run_reg <= 16'h0000;
          if (cancel_req) begin
            cancel_done <= 1'b1;
          end else if (byte_valid && !is_fill) begin
            state_reg <= DPC_ST_PLAY;
          end
        end
        DPC_ST_PLAY: begin
          if (cancel_req) begin
            state_reg <= DPC_ST_CANCEL;
            run_reg <= 16'h0000;
          end else if (byte_valid && is_fill) begin
            // Long run of fill bytes means the stream has ended
            if (run_reg == 16'(IDLE_FILL - 1)) begin
              state_reg <= DPC_ST_IDLE;
            end
            run_reg <= run_reg + 16'h0001;
          end else if (byte_valid) begin
            run_reg <= 16'h0000;
          end
        end
        DPC_ST_CANCEL: begin
          if (byte_valid) begin
            if (run_reg == 16'(CANCEL_BYTES - 1)) begin
              state_reg <= DPC_ST_IDLE;
              cancel_done <= 1'b1;
            end
            run_reg <= run_reg + 16'h0001;
          end
        end
        default: begin
          state_reg <= DPC_ST_IDLE;
        end
      endcase
    end
  end

  // Header region: random access would lose sync
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_reg <= 16'h0000;
    end else if (state_reg == DPC_ST_IDLE || restart) begin
      hdr_reg <= 16'h0000;
    end else if (byte_valid && hdr_reg != 16'(HEADER_BYTES)) begin
      hdr_reg <= hdr_reg + 16'h0001;
    end
  end

  assign decoding = state_reg != DPC_ST_IDLE;
  assign no_jump = decoding && hdr_reg != 16'(HEADER_BYTES);

  a_cancel_ends: assert property (@(posedge clk) disable iff (!rst_n)
    cancel_done |-> state_reg == DPC_ST_IDLE)
    else $error("Cancel reported while still decoding");

endmodule

//--- logic/dpc_top.sv
// What this block does
// - Clock-range bit set halves the incoming clock for internal use.
// - Hard reset clears all control state asynchronously and stops clocks.
// - During hard reset every output sits at its default value.
// - After reset data request stays low about 22000 internal cycles.
// - Multiplier 1.0 to 5.0 via clock register, 1.0 after reset.
// - Soft reset bit restarts decoder and the data request hold-off.
// - Clock register zero selects 1.0 times and turns the PLL off.
// - Sample-rate register write sets the audio rate directly.
// - Volume 0xffff switches the analog drivers off.
// - No decodable data: header registers zero, device idles watching input.
// - Play speed above one plays faster; writing one restores normal.
// - Play speed survives the end of one song and start of next.
// - No-jump status bit is set while random access is unsafe.
// - Decode seconds are never adjusted for host jumps.
// - Position reads minus one when exact position is unknown.
// - Byte rate reports nominal-speed data rate even in fast play.
`timescale 1ns/1ps
`include "dpc_cfg.svh"

module dpc_top
  import dpc_pkg::*;
#(
  parameter int HOLDOFF_CYCLES = `DPC_HOLDOFF_CYCLES,
  parameter int SEC_CYCLES = `DPC_SEC_CYCLES,
  parameter int MS_CYCLES = `DPC_MS_CYCLES,
  parameter int IDLE_FILL = `DPC_IDLE_FILL_BYTES,
  parameter int CANCEL_BYTES = `DPC_CANCEL_BYTES,
  parameter int HEADER_BYTES = `DPC_HEADER_BYTES,
  // Arbitrary format tag shown while decoding
  parameter logic [15:0] FORMAT_TAG = 16'h5a5a,
  parameter logic [15:0] NOM_BYTE_RATE = 16'h3e80
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [7:0] AUDIO_BYTE,
  input wire logic AUDIO_VALID,
  output logic DATA_REQUEST,
  output logic CORE_TICK,
  output logic CLOCKS_RUN,
  output logic PLL_ENABLE,
  output logic [2:0] PLL_MULT,
  output logic ANALOG_ON,
  output logic [15:0] SAMPLE_RATE,
  output logic CORE_IDLE
);

  logic rst_meta, rst_n;
  dpc_bus_state_t bus_state_reg;
  logic [4:0] addr_reg;
  logic addr_ok_reg, take, wr_en, soft_rst, holdoff_done;
  logic decoding, no_jump, cancel_done;
  logic [31:0] rd_next;
  logic [15:0] mode_control_reg, tone_control_reg, clock_multiplier_reg;
  logic [15:0] decode_time_reg, sample_rate_reg, volume_reg;
  logic [15:0] play_speed_param, header_info_low, header_info_high;
  logic [15:0] pos_reg, position_ms_param;
  logic [31:0] sec_cnt_reg, ms_cnt_reg;
  logic tick_reg, range;

  ////////////////////////////////////////////////////////////////////////
  // Reset release is synchronised, assertion stays asynchronous
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Clocks counted as stopped while in reset
  assign CLOCKS_RUN = rst_n;

  ////////////////////////////////////////////////////////////////////////
  // Zero-wait writes; reads take one wait state so a write just before
  // a read to the same register is always seen
  assign take = HSEL && HTRANS[1] && HREADY;
  assign wr_en = bus_state_reg == DPC_BUS_WR && addr_ok_reg;
  assign HREADYOUT = bus_state_reg != DPC_BUS_RD1;
  assign HRESP = 1'b0;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_reg <= DPC_BUS_IDLE;
      addr_reg <= 5'h00;
      addr_ok_reg <= 1'b0;
    end else if (bus_state_reg == DPC_BUS_RD1) begin
      bus_state_reg <= DPC_BUS_RD2;
    end else if (take) begin
      bus_state_reg <= HWRITE ? DPC_BUS_WR : DPC_BUS_RD1;
      addr_reg <= HADDR[6:2];
      addr_ok_reg <= HADDR[31:7] == 25'h0000000;
    end else begin
      bus_state_reg <= DPC_BUS_IDLE;
    end
  end

  always_comb begin
    rd_next = 32'h00000000;
    if (addr_ok_reg) begin
      unique case (addr_reg)
        `DPC_IDX_MODE: rd_next[15:0] = mode_control_reg;
        `DPC_IDX_STATUS: begin
          rd_next[`DPC_STAT_DECODING_BIT] = decoding;
          rd_next[`DPC_STAT_NOJUMP_BIT] = no_jump;
        end
        `DPC_IDX_TONE: rd_next[15:0] = tone_control_reg;
        `DPC_IDX_CLOCK: rd_next[15:0] = clock_multiplier_reg;
        `DPC_IDX_DTIME: rd_next[15:0] = decode_time_reg;
        `DPC_IDX_SRATE: rd_next[15:0] = sample_rate_reg;
        `DPC_IDX_HDR_LO: rd_next[15:0] = header_info_low;
        `DPC_IDX_HDR_HI: rd_next[15:0] = header_info_high;
        `DPC_IDX_VOLUME: rd_next[15:0] = volume_reg;
        `DPC_IDX_FILL: rd_next[7:0] = `DPC_FILL_RST;
        `DPC_IDX_SPEED: rd_next[15:0] = play_speed_param;
        `DPC_IDX_BRATE: rd_next[15:0] = NOM_BYTE_RATE;
        `DPC_IDX_POS: rd_next[15:0] = position_ms_param;
        default: rd_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA <= 32'h00000000;
    end else if (bus_state_reg == DPC_BUS_RD1) begin
      HRDATA <= rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode register: soft reset bit self-clears, a host write of the cancel
  // bit beats the hardware clear in the same cycle
  assign soft_rst = mode_control_reg[`DPC_MODE_RESET_BIT];
  assign range = mode_control_reg[`DPC_MODE_RANGE_BIT];

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_control_reg <= `DPC_MODE_RST;
    end else if (wr_en && addr_reg == `DPC_IDX_MODE) begin
      mode_control_reg <= HWDATA[15:0];
    end else begin
      mode_control_reg[`DPC_MODE_RESET_BIT] <= 1'b0;
      if (cancel_done) begin
        mode_control_reg[`DPC_MODE_CANCEL_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tone_control_reg <= 16'h0000;
      clock_multiplier_reg <= `DPC_CLOCK_RST;
      sample_rate_reg <= 16'h0000;
      volume_reg <= `DPC_VOLUME_RST;
    end else if (wr_en) begin
      // Volume survives soft reset on purpose
      unique case (addr_reg)
        `DPC_IDX_TONE: tone_control_reg <= HWDATA[15:0];
        `DPC_IDX_CLOCK: clock_multiplier_reg <= HWDATA[15:0];
        `DPC_IDX_SRATE: sample_rate_reg <= HWDATA[15:0];
        `DPC_IDX_VOLUME: volume_reg <= HWDATA[15:0];
        default: tone_control_reg <= tone_control_reg;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      play_speed_param <= `DPC_SPEED_RST;
    end else if (wr_en && addr_reg == `DPC_IDX_SPEED) begin
      play_speed_param <= HWDATA[15:0];
    end
  end
  // Play speed is not touched when a stream ends

  ////////////////////////////////////////////////////////////////////////
  // Internal clock tick: every cycle, or every second one in range mode
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_reg <= 1'b1;
    end else begin
      tick_reg <= range ? !tick_reg : 1'b1;
    end
  end
  assign CORE_TICK = tick_reg;

  dpc_holdoff #(
    .CYCLES(HOLDOFF_CYCLES)
  ) u_holdoff (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .restart(soft_rst),
    .tick(tick_reg),
    .done(holdoff_done)
  );

  assign DATA_REQUEST = holdoff_done;

  dpc_stream #(
    .IDLE_FILL(IDLE_FILL),
    .CANCEL_BYTES(CANCEL_BYTES),
    .HEADER_BYTES(HEADER_BYTES)
  ) u_stream (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .restart(soft_rst),
    .byte_in(AUDIO_BYTE),
    .byte_valid(AUDIO_VALID && holdoff_done),
    .fill_byte(`DPC_FILL_RST),
    .cancel_req(mode_control_reg[`DPC_MODE_CANCEL_BIT]),
    .decoding(decoding),
    .no_jump(no_jump),
    .cancel_done(cancel_done)
  );

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      header_info_low <= 16'h0000;
      header_info_high <= 16'h0000;
      CORE_IDLE <= 1'b1;
      ANALOG_ON <= 1'b1;
      PLL_ENABLE <= 1'b0;
      PLL_MULT <= 3'h0;
      SAMPLE_RATE <= 16'h0000;
    end else begin
      header_info_low <= decoding ? NOM_BYTE_RATE : 16'h0000;
      header_info_high <= decoding ? FORMAT_TAG : 16'h0000;
      CORE_IDLE <= !decoding;
      ANALOG_ON <= volume_reg != `DPC_VOLUME_OFF;
      PLL_ENABLE <= clock_multiplier_reg != 16'h0000;
      PLL_MULT <= clock_multiplier_reg[`DPC_MULT_HI:`DPC_MULT_LO];
      SAMPLE_RATE <= sample_rate_reg;
    end
  end

  // Seconds advance by the play speed; host jumps are not seen here
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt_reg <= 32'h00000000;
      decode_time_reg <= 16'h0000;
    end else if (soft_rst) begin
      sec_cnt_reg <= 32'h00000000;
      decode_time_reg <= 16'h0000;
    end else if (wr_en && addr_reg == `DPC_IDX_DTIME) begin
      decode_time_reg <= HWDATA[15:0];
    end else if (decoding) begin
      if (sec_cnt_reg == 32'(SEC_CYCLES - 1)) begin
        sec_cnt_reg <= 32'h00000000;
        decode_time_reg <= decode_time_reg + play_speed_param;
      end else begin
        sec_cnt_reg <= sec_cnt_reg + 32'h00000001;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_reg <= 32'h00000000;
      pos_reg <= 16'h0000;
    end else if (!decoding) begin
      ms_cnt_reg <= 32'h00000000;
      pos_reg <= 16'h0000;
    end else if (ms_cnt_reg == 32'(MS_CYCLES - 1)) begin
      ms_cnt_reg <= 32'h00000000;
      pos_reg <= pos_reg + play_speed_param;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
    end
  end

  // Position is only trusted while a stream is being decoded
  assign position_ms_param = decoding ? pos_reg : `DPC_POS_NONE;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);

  a_range_halves: assert property (range && tick_reg |=> !tick_reg)
    else $error("Divided clock ticked twice in a row");
  a_reset_idle: assert property (@(posedge SYS_CLK) disable iff (1'b0)
    !rst_n |-> !CLOCKS_RUN && !DATA_REQUEST && HRDATA == 32'h0)
    else $error("Outputs not at default during reset");
  a_soft_holdoff: assert property (soft_rst |=> !DATA_REQUEST [*8])
    else $error("Data request rose too soon after soft reset");
  a_pll_off: assert property (wr_en && addr_reg == `DPC_IDX_CLOCK
    && HWDATA[15:0] == 16'h0000 |=> ##1 !PLL_ENABLE)
    else $error("PLL still on after zero clock write");
  a_rate_write: assert property (wr_en && addr_reg == `DPC_IDX_SRATE
    |=> ##1 SAMPLE_RATE == $past(HWDATA[15:0], 2))
    else $error("Sample rate not taken");
  a_analog_off: assert property (wr_en && addr_reg == `DPC_IDX_VOLUME
    && HWDATA[15:0] == `DPC_VOLUME_OFF |=> ##1 !ANALOG_ON)
    else $error("Analog drivers on after power-down volume");
  a_header_zero: assert property (!decoding |=> header_info_low == 16'h0
    && header_info_high == 16'h0)
    else $error("Header info not cleared without data");
  a_speed_restore: assert property (wr_en && addr_reg == `DPC_IDX_SPEED
    && HWDATA[15:0] == 16'h0001 |=> play_speed_param == 16'h0001)
    else $error("Play speed not restored");
  a_speed_kept: assert property ($fell(decoding) |-> $stable(play_speed_param)
    )
    else $error("Play speed changed at stream end");
  a_pos_unknown: assert property (bus_state_reg == DPC_BUS_RD1
    && addr_reg == `DPC_IDX_POS && addr_ok_reg && !decoding
    |=> HRDATA[15:0] == `DPC_POS_NONE)
    else $error("Position not minus one while idle");
  a_rate_nominal: assert property (bus_state_reg == DPC_BUS_RD1
    && addr_reg == `DPC_IDX_BRATE && addr_ok_reg
    |=> HRDATA[15:0] == NOM_BYTE_RATE)
    else $error("Byte rate not nominal");
  a_cancel_held: assert property (mode_control_reg[`DPC_MODE_CANCEL_BIT]
    && !cancel_done && !wr_en |=> mode_control_reg[`DPC_MODE_CANCEL_BIT])
    else $error("Cancel bit cleared before decoding stopped");

  c_soft_reset: cover property (soft_rst ##1 !DATA_REQUEST);
  c_cancel_done: cover property (cancel_done);
  c_no_jump: cover property ($fell(no_jump) && decoding);
  c_fast_play: cover property (decoding && play_speed_param > 16'h0001);

endmodule

//--- testbench/dpc_host_feed.sv
`timescale 1ns/1ps

module dpc_host_feed (
  input wire logic clk,
  input wire logic data_request,
  output logic [7:0] byte_out,
  output logic valid
);
  initial begin
    byte_out = 8'h00;
    valid = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offers one byte a cycle; a byte shown while data request is low would be
  // dropped, so the host stalls and shows the inverted byte with valid low instead
  task automatic send(input int n, input logic [7:0] v);
    int k;
    k = 0;
    while (k < n) begin
      if (data_request === 1'b1) begin
        byte_out <= v;
        valid <= 1'b1;
        k++;
      end else begin
        byte_out <= ~v;
        valid <= 1'b0;
      end
      @(posedge clk);
    end
    byte_out <= ~v;
    valid <= 1'b0;
  endtask
endmodule

//--- testbench/tb_decoder_reset_playback_control.sv
`timescale 1ns/1ps
`include "dpc_cfg.svh"

module tb_decoder_reset_playback_control;
  typedef struct packed {
    logic [31:0] a;
    logic [15:0] d;
    logic [15:0] r;
    logic [20:0] o;
  } dpc_row_t;

  logic SYS_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  logic HREADY;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, DATA_REQUEST, CORE_TICK, CLOCKS_RUN;
  logic PLL_ENABLE, ANALOG_ON, CORE_IDLE, AUDIO_VALID, t;
  logic [2:0] PLL_MULT;
  logic [15:0] SAMPLE_RATE, rd;
  logic [7:0] AUDIO_BYTE;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  dpc_row_t rows [13];
  localparam logic [20:0] O5 = {1'b0, 3'h0, 1'b1, 16'h0010};

  assign HREADY = HREADYOUT;
  always #25 SYS_CLK = ~SYS_CLK;

  dpc_top #(.HOLDOFF_CYCLES(20), .SEC_CYCLES(50),
    .IDLE_FILL(8), .CANCEL_BYTES(4), .HEADER_BYTES(4)) DUT (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .AUDIO_BYTE(AUDIO_BYTE), .AUDIO_VALID(AUDIO_VALID),
    .DATA_REQUEST(DATA_REQUEST), .CORE_TICK(CORE_TICK),
    .CLOCKS_RUN(CLOCKS_RUN), .PLL_ENABLE(PLL_ENABLE),
    .PLL_MULT(PLL_MULT), .ANALOG_ON(ANALOG_ON),
    .SAMPLE_RATE(SAMPLE_RATE), .CORE_IDLE(CORE_IDLE));

  dpc_host_feed HOST (.clk(SYS_CLK), .data_request(DATA_REQUEST),
    .byte_out(AUDIO_BYTE), .valid(AUDIO_VALID));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] adr(input logic [4:0] i);
    return {25'h0, i, 2'b00};
  endfunction

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic summarize;
    $display("Compares %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Ready is looked at on the falling edge, where it has settled, and the
  // phase ends at the following rising edge
  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [15:0] d, output logic [15:0] r);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    do @(negedge SYS_CLK); while (HREADYOUT !== 1'b1);
    @(posedge SYS_CLK);
    HTRANS <= 2'h0;
    HWDATA <= {16'h0000, d};
    do @(negedge SYS_CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA[15:0];
    chk(HRESP, 0);
    @(posedge SYS_CLK);
  endtask

  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    bus(adr(i), 1'b1, d, rd);
  endtask

  task automatic rdc(input logic [4:0] i, input logic [15:0] e);
    bus(adr(i), 1'b0, 16'h0000, rd);
    chk(rd, e);
  endtask

  task automatic holdoff(input int lo, input int hi);
    int n;
    n = 0;
    while (DATA_REQUEST !== 1'b1 && n < hi) begin
      @(negedge SYS_CLK);
      n++;
    end
    chk(n >= lo && n < hi, 1);
    @(posedge SYS_CLK);
  endtask

  // Limit well above the few hundred cycles the sequence needs
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{
      '{adr(`DPC_IDX_CLOCK), 16'h9800, 16'h9800, {1'b1, 3'h4, 1'b1, 16'h0}},
      '{adr(`DPC_IDX_SRATE), 16'h0010, 16'h0010, {1'b1, 3'h4, 1'b1, 16'h10}},
      '{adr(`DPC_IDX_VOLUME), 16'hffff, 16'hffff, {1'b1, 3'h4, 1'b0, 16'h10}},
      '{adr(`DPC_IDX_CLOCK), 16'h0000, 16'h0000, {1'b0, 3'h0, 1'b0, 16'h10}},
      '{adr(`DPC_IDX_VOLUME), 16'h0000, 16'h0000, O5},
      '{adr(`DPC_IDX_FILL), 16'h00ab, 16'h0000, O5},
      '{adr(`DPC_IDX_HDR_LO), 16'h1234, 16'h0000, O5},
      '{32'h0000_0080, 16'h5555, 16'h0000, O5},
      '{adr(`DPC_IDX_SPEED), 16'h0003, 16'h0003, O5},
      '{adr(`DPC_IDX_SPEED), 16'h0001, 16'h0001, O5},
      '{adr(`DPC_IDX_TONE), 16'h00a5, 16'h00a5, O5},
      '{adr(`DPC_IDX_DTIME), 16'h0123, 16'h0123, O5},
      '{adr(`DPC_IDX_SPEED), 16'h0003, 16'h0003, O5}};
    repeat (3) @(posedge SYS_CLK);
    chk({DATA_REQUEST, CLOCKS_RUN, PLL_ENABLE, PLL_MULT, ANALOG_ON,
         CORE_IDLE}, 8'h03);
    repeat (2) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    wr(`DPC_IDX_MODE, 16'h8000);
    @(negedge SYS_CLK);
    t = CORE_TICK;
    @(negedge SYS_CLK);
    chk(CORE_TICK, !t);
    holdoff(25, 90);
    wr(`DPC_IDX_MODE, 16'h0000);
    foreach (rows[i]) begin
      bus(rows[i].a, 1'b1, rows[i].d, rd);
      bus(rows[i].a, 1'b0, 16'h0000, rd);
      chk({rd, PLL_ENABLE, PLL_MULT, ANALOG_ON, SAMPLE_RATE},
          {rows[i].r, rows[i].o});
    end
    HOST.send(1, 8'h11);
    repeat (2) @(posedge SYS_CLK);
    rdc(`DPC_IDX_STATUS, 16'h8001);
    rdc(`DPC_IDX_HDR_HI, 16'h5a5a);
    chk(CORE_IDLE, 0);
    HOST.send(4, 8'h22);
    repeat (2) @(posedge SYS_CLK);
    rdc(`DPC_IDX_STATUS, 16'h0001);
    rdc(`DPC_IDX_BRATE, 16'h3e80);
    bus(adr(`DPC_IDX_POS), 1'b0, 16'h0000, rd);
    chk(rd === 16'hffff, 0);
    HOST.send(12, `DPC_FILL_RST);
    repeat (2) @(posedge SYS_CLK);
    rdc(`DPC_IDX_HDR_LO, 16'h0000);
    rdc(`DPC_IDX_HDR_HI, 16'h0000);
    rdc(`DPC_IDX_POS, 16'hffff);
    rdc(`DPC_IDX_SPEED, 16'h0003);
    chk(CORE_IDLE, 1);
    HOST.send(2, 8'h33);
    wr(`DPC_IDX_MODE, 16'h0008);
    rdc(`DPC_IDX_MODE, 16'h0008);
    HOST.send(4, 8'h44);
    repeat (2) @(posedge SYS_CLK);
    rdc(`DPC_IDX_MODE, 16'h0000);
    // Cancel left pending with no bytes: the host gives up and soft-resets
    HOST.send(1, 8'h55);
    wr(`DPC_IDX_MODE, 16'h0008);
    rdc(`DPC_IDX_MODE, 16'h0008);
    wr(`DPC_IDX_MODE, 16'h000c);
    @(posedge SYS_CLK);
    holdoff(12, 40);
    rdc(`DPC_IDX_MODE, 16'h0000);
    rdc(`DPC_IDX_DTIME, 16'h0000);
    rdc(`DPC_IDX_SPEED, 16'h0003);
    wr(`DPC_IDX_CLOCK, 16'h9800);
    @(posedge SYS_CLK);
    RST_B <= 1'b0;
    #1;
    chk(PLL_ENABLE, 0);
    repeat (5) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    holdoff(15, 40);
    chk(CLOCKS_RUN, 1);
    rdc(`DPC_IDX_SPEED, 16'h0001);
    rdc(`DPC_IDX_CLOCK, 16'h0000);
    summarize();
  end
endmodule
